/* File: rtl/uct_map.svh */
`ifndef UCT_MAP_SVH
`define UCT_MAP_SVH

// Register offsets on the host port
`define UCT_OFS_DATA      4'h0
`define UCT_OFS_IRQ_EN    4'h1
`define UCT_OFS_FIFO_ISR  4'h2
`define UCT_OFS_LINE_CTL  4'h3
`define UCT_OFS_MODEM     4'h4
`define UCT_OFS_LINE_STS  4'h5
`define UCT_OFS_DIV_LO    4'h6
`define UCT_OFS_DIV_HI    4'h7
`define UCT_OFS_FEATURE   4'h8

// Field positions
`define UCT_FCR_FIFO_EN   0
`define UCT_FCR_TX_RST    2
`define UCT_FCR_BLOCK     3
`define UCT_IER_RX        0
`define UCT_IER_TX        1
`define UCT_LCR_STOP2     2
`define UCT_LCR_PAR_EN    3
`define UCT_LCR_PAR_EVEN  4
`define UCT_MCR_PRESCALE  7
`define UCT_FEATURE_CONTROL_REG_TX_EMPTY 3
`define UCT_LSR_DATA      0
`define UCT_LSR_THR_EMPTY 5
`define UCT_LSR_TX_EMPTY  6

// Interrupt source codes
`define UCT_ISR_NONE      8'h01
`define UCT_ISR_THR       8'h02
`define UCT_ISR_RX        8'h04
`define UCT_ISR_TIMEOUT   8'h0c

// Reset values
`define UCT_RST_BYTE      8'h00
`define UCT_RST_DIV       16'h0000

// Sizes and timing
`define UCT_FIFO_DEPTH    8'h80
`define UCT_HOLD_DEPTH    8'h01
`define UCT_PRESCALE_MAX  2'h3
`define UCT_BIT_TICKS     4'hf
`define UCT_WORD_BASE     4'h5
`define UCT_TO_CHARS      4
`define UCT_TO_EXTRA      12
`define UCT_TICKS_PER_BIT 16

`endif

/* File: rtl/uct_pkg.sv */
package uct_pkg;

    // Transmit shifter phases
    typedef enum logic [2:0] {
        UCT_TX_IDLE,
        UCT_TX_START,
        UCT_TX_DATA,
        UCT_TX_PARITY,
        UCT_TX_STOP
    } uct_tx_state_t;

endpackage : uct_pkg

/* File: rtl/uct_channel.sv */
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uct_map.svh"

module uct_channel (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Host register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Trigger levels from the trigger selection logic
    input  wire logic [7:0] tx_trigger,
    input  wire logic [7:0] rx_trigger,
    // Receive FIFO status from the receiver, and the pop pulse back to it
    input  wire logic [7:0] rx_level,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_char_in,
    output logic            rx_pop,
    // Serial and status pins
    output logic            tx_serial,
    output logic            irq_tx,
    output logic            irq_rx,
    output logic            rx_ready_n,
    output logic            tx_ready_n,
    output logic            rx_timeout
);

    // Data bits per word from the line control length field
    function automatic logic [3:0] word_bits(input logic [7:0] lcr);
        word_bits = `UCT_WORD_BASE + {2'h0, lcr[1:0]};
    endfunction : word_bits

    // Software registers
    logic [7:0]  irq_enable_reg;       // Interrupt enables
    logic [7:0]  fifo_control_reg;     // FIFO enable and block mode
    logic [7:0]  line_control_reg;     // Framing
    logic [7:0]  modem_control_reg;    // Prescaler select
    logic [7:0]  feature_control_reg;  // Tx interrupt selection
    logic [7:0]  divisor_low_byte;     // Divisor low byte
    logic [7:0]  divisor_high_byte;    // Divisor high byte

    // Transmit FIFO storage and pointers
    logic [7:0]  tx_mem [0:127];       // Holding register plus FIFO
    logic [6:0]  tx_wptr_reg;          // Write pointer
    logic [6:0]  tx_rptr_reg;          // Read pointer
    logic [7:0]  tx_count_reg;         // Bytes held

    // Rate generation
    logic [1:0]  pre_cnt_reg;          // Prescaler count
    logic [15:0] div_cnt_reg;          // Divisor count
    logic        tick16_reg;           // 16x sample enable

    // Transmit shifter
    uct_pkg::uct_tx_state_t tx_state_reg;
    logic [7:0]  tx_shift_reg;         // Bits on their way out
    logic [3:0]  tick_cnt_reg;         // Ticks within one bit
    logic [3:0]  bit_cnt_reg;          // Data or stop bit index
    logic        parity_reg;           // Parity for current word

    // Flags and counters
    logic        thre_flag_reg;        // Latched holding-empty event
    logic        thr_empty_q_reg;      // Previous holding-empty level
    logic [9:0]  to_cnt_reg;           // Rx idle time in ticks

    // Decodes
    logic        fifo_en;
    logic        block_mode;
    logic [7:0]  tx_cap;
    logic        tx_push;
    logic        tx_pop;
    logic        tx_flush;
    logic        thr_empty;
    logic        tsr_empty;
    logic        bit_end;
    logic [15:0] divisor;
    logic [9:0]  to_limit;
    logic [7:0]  isr_value;
    logic        rx_irq_level;
    logic [7:0]  load_byte;
    logic [7:0]  load_mask;

    assign fifo_en    = fifo_control_reg[`UCT_FCR_FIFO_EN];
    // Block bit counts only with FIFOs on; otherwise single-character
    assign block_mode = fifo_en & fifo_control_reg[`UCT_FCR_BLOCK];
    // Non-FIFO mode uses one slot of the same array as holding register
    assign tx_cap     = fifo_en ? `UCT_FIFO_DEPTH : `UCT_HOLD_DEPTH;
    // Bus is sampled on clk_sys; a strobe acts once in each cycle it is high
    assign tx_push    = reg_wr & (reg_addr == `UCT_OFS_DATA)
                      & (tx_count_reg < tx_cap);
    assign tx_flush   = reg_wr & (reg_addr == `UCT_OFS_FIFO_ISR)
                      & (reg_wdata[`UCT_FCR_TX_RST]
                         | (reg_wdata[`UCT_FCR_FIFO_EN] != fifo_en));
    assign tx_pop     = (tx_state_reg == uct_pkg::UCT_TX_IDLE)
                      & (tx_count_reg != `UCT_RST_BYTE) & ~tx_flush;
    assign thr_empty  = (tx_count_reg == `UCT_RST_BYTE);
    assign tsr_empty  = thr_empty
                      & (tx_state_reg == uct_pkg::UCT_TX_IDLE);
    assign bit_end    = tick16_reg & (tick_cnt_reg == `UCT_BIT_TICKS);
    assign divisor    = {divisor_high_byte, divisor_low_byte};
    assign to_limit   = 10'((`UCT_TO_CHARS * word_bits(line_control_reg)
                        + `UCT_TO_EXTRA) * `UCT_TICKS_PER_BIT);
    assign rx_irq_level = fifo_en ? (rx_level >= rx_trigger)
                                  : (rx_level != `UCT_RST_BYTE);
    assign load_byte  = tx_mem[tx_rptr_reg];
    assign load_mask  = 8'(9'h0ff >> (4'h8 - word_bits(line_control_reg)));

    // Interrupt source code, highest priority first
    always_comb begin
        if (rx_timeout && irq_enable_reg[`UCT_IER_RX]) begin
            isr_value = `UCT_ISR_TIMEOUT;
        end else if (rx_irq_level && irq_enable_reg[`UCT_IER_RX]) begin
            isr_value = `UCT_ISR_RX;
        end else if (thre_flag_reg && irq_enable_reg[`UCT_IER_TX]) begin
            isr_value = `UCT_ISR_THR;
        end else begin
            isr_value = `UCT_ISR_NONE;
        end
    end

    // Software register writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_enable_reg      <= `UCT_RST_BYTE;
            fifo_control_reg    <= `UCT_RST_BYTE;
            line_control_reg    <= `UCT_RST_BYTE;
            modem_control_reg   <= `UCT_RST_BYTE;
            feature_control_reg <= `UCT_RST_BYTE;
            divisor_low_byte    <= `UCT_RST_BYTE;
            divisor_high_byte   <= `UCT_RST_BYTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `UCT_OFS_IRQ_EN:   irq_enable_reg      <= reg_wdata;
                `UCT_OFS_FIFO_ISR: fifo_control_reg    <= reg_wdata;
                `UCT_OFS_LINE_CTL: line_control_reg    <= reg_wdata;
                `UCT_OFS_MODEM:    modem_control_reg   <= reg_wdata;
                `UCT_OFS_DIV_LO:   divisor_low_byte    <= reg_wdata;
                `UCT_OFS_DIV_HI:   divisor_high_byte   <= reg_wdata;
                `UCT_OFS_FEATURE:  feature_control_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= `UCT_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `UCT_OFS_DATA:     reg_rdata <= rx_data;
                `UCT_OFS_IRQ_EN:   reg_rdata <= irq_enable_reg;
                `UCT_OFS_FIFO_ISR: reg_rdata <= isr_value;
                `UCT_OFS_LINE_CTL: reg_rdata <= line_control_reg;
                `UCT_OFS_MODEM:    reg_rdata <= modem_control_reg;
                `UCT_OFS_LINE_STS: begin
                    reg_rdata <= `UCT_RST_BYTE;
                    reg_rdata[`UCT_LSR_DATA]      <=
                        (rx_level != `UCT_RST_BYTE);
                    reg_rdata[`UCT_LSR_THR_EMPTY] <= thr_empty;
                    reg_rdata[`UCT_LSR_TX_EMPTY]  <= tsr_empty;
                end
                `UCT_OFS_DIV_LO:   reg_rdata <= divisor_low_byte;
                `UCT_OFS_DIV_HI:   reg_rdata <= divisor_high_byte;
                `UCT_OFS_FEATURE:  reg_rdata <= feature_control_reg;
                default:           reg_rdata <= `UCT_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `UCT_RST_BYTE;
        end
    end

    // Receive pop pulse to the receiver on a data read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_pop <= 1'b0;
        end else begin
            rx_pop <= reg_rd & (reg_addr == `UCT_OFS_DATA)
                    & (rx_level != `UCT_RST_BYTE);
        end
    end

    // Prescaler and divisor; the only clock is clk_sys
    // A zero divisor parks the generator, so nothing shifts
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_cnt_reg <= 2'h0;
            div_cnt_reg <= `UCT_RST_DIV;
            tick16_reg  <= 1'b0;
        end else begin
            tick16_reg <= 1'b0;
            if (!modem_control_reg[`UCT_MCR_PRESCALE]
                || pre_cnt_reg == `UCT_PRESCALE_MAX) begin
                pre_cnt_reg <= 2'h0;
                if (divisor == `UCT_RST_DIV) begin
                    div_cnt_reg <= `UCT_RST_DIV;
                end else if (div_cnt_reg >= divisor - 16'h1) begin
                    div_cnt_reg <= `UCT_RST_DIV;
                    tick16_reg  <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 16'h1;
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 2'h1;
            end
        end
    end

    // FIFO storage; no reset needed for data words
    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_mem[tx_wptr_reg] <= reg_wdata;
        end
    end

    // FIFO pointers and fill count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_wptr_reg  <= 7'h0;
            tx_rptr_reg  <= 7'h0;
            tx_count_reg <= `UCT_RST_BYTE;
        end else if (tx_flush) begin
            tx_wptr_reg  <= 7'h0;
            tx_rptr_reg  <= 7'h0;
            tx_count_reg <= `UCT_RST_BYTE;
        end else begin
            if (tx_push) begin
                tx_wptr_reg <= tx_wptr_reg + 7'h1;
            end
            if (tx_pop) begin
                tx_rptr_reg <= tx_rptr_reg + 7'h1;
            end
            if (tx_push && !tx_pop) begin
                tx_count_reg <= tx_count_reg + 8'h1;
            end else if (tx_pop && !tx_push) begin
                tx_count_reg <= tx_count_reg - 8'h1;
            end
        end
    end

    // Tick counter within one bit cell
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 4'h0;
        end else if (tx_pop) begin
            tick_cnt_reg <= 4'h0;
        end else if (tick16_reg) begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
        end
    end

    // Transmit shifter sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_state_reg <= uct_pkg::UCT_TX_IDLE;
            tx_shift_reg <= `UCT_RST_BYTE;
            bit_cnt_reg  <= 4'h0;
            parity_reg   <= 1'b0;
        end else begin
            unique case (tx_state_reg)
                uct_pkg::UCT_TX_IDLE: begin
                    if (tx_pop) begin
                        tx_shift_reg <= load_byte & load_mask;
                        // Even parity: xor of data; odd: its inverse
                        parity_reg   <= ^(load_byte & load_mask)
                            ^ ~line_control_reg[`UCT_LCR_PAR_EVEN];
                        tx_state_reg <= uct_pkg::UCT_TX_START;
                    end
                end
                uct_pkg::UCT_TX_START: begin
                    if (bit_end) begin
                        bit_cnt_reg  <= 4'h0;
                        tx_state_reg <= uct_pkg::UCT_TX_DATA;
                    end
                end
                uct_pkg::UCT_TX_DATA: begin
                    if (bit_end) begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == word_bits(line_control_reg)
                            - 4'h1) begin
                            bit_cnt_reg  <= 4'h0;
                            tx_state_reg <=
                                line_control_reg[`UCT_LCR_PAR_EN]
                                ? uct_pkg::UCT_TX_PARITY
                                : uct_pkg::UCT_TX_STOP;
                        end
                    end
                end
                uct_pkg::UCT_TX_PARITY: begin
                    if (bit_end) begin
                        tx_state_reg <= uct_pkg::UCT_TX_STOP;
                    end
                end
                uct_pkg::UCT_TX_STOP: begin
                    if (bit_end) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        // Idle only after the last stop cell ends
                        if (!line_control_reg[`UCT_LCR_STOP2]
                            || bit_cnt_reg != 4'h0) begin
                            tx_state_reg <= uct_pkg::UCT_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Serial line level, idle high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_serial <= 1'b1;
        end else begin
            unique case (tx_state_reg)
                uct_pkg::UCT_TX_START:  tx_serial <= 1'b0;
                uct_pkg::UCT_TX_DATA:   tx_serial <= tx_shift_reg[0];
                uct_pkg::UCT_TX_PARITY: tx_serial <= parity_reg;
                default:                tx_serial <= 1'b1;
            endcase
        end
    end

    // Holding-empty event flag; a new event beats a clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            thr_empty_q_reg <= 1'b1;
            thre_flag_reg   <= 1'b0;
        end else begin
            thr_empty_q_reg <= thr_empty;
            if (thr_empty && !thr_empty_q_reg) begin
                thre_flag_reg <= 1'b1;
            end else if (tx_push
                || (reg_rd && reg_addr == `UCT_OFS_FIFO_ISR
                    && isr_value == `UCT_ISR_THR)) begin
                thre_flag_reg <= 1'b0;
            end
        end
    end

    // Receive idle timer, counted in 16x ticks
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            to_cnt_reg <= 10'h0;
            rx_timeout <= 1'b0;
        end else if (rx_char_in || rx_pop
                     || rx_level == `UCT_RST_BYTE) begin
            to_cnt_reg <= 10'h0;
            rx_timeout <= 1'b0;
        end else if (tick16_reg) begin
            if (to_cnt_reg >= to_limit - 10'h1) begin
                rx_timeout <= 1'b1;
            end else begin
                to_cnt_reg <= to_cnt_reg + 10'h1;
            end
        end
    end

    // Interrupt pins, one cycle behind their causes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_tx <= 1'b0;
            irq_rx <= 1'b0;
        end else begin
            if (!fifo_en) begin
                irq_tx <= irq_enable_reg[`UCT_IER_TX]
                    & (feature_control_reg[`UCT_FEATURE_CONTROL_REG_TX_EMPTY]
                       ? tsr_empty : thr_empty);
            end else begin
                irq_tx <= irq_enable_reg[`UCT_IER_TX]
                    & ((tx_count_reg < tx_trigger)
                       | (feature_control_reg[`UCT_FEATURE_CONTROL_REG_TX_EMPTY]
                          ? tsr_empty : thr_empty));
            end
            irq_rx <= irq_enable_reg[`UCT_IER_RX]
                & (rx_irq_level | (fifo_en & rx_timeout));
        end
    end

    // Receive-ready pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_ready_n <= 1'b1;
        end else if (!block_mode) begin
            rx_ready_n <= (rx_level == `UCT_RST_BYTE);
        end else if (rx_level == `UCT_RST_BYTE) begin
            rx_ready_n <= 1'b1;
        end else if (rx_level >= rx_trigger || rx_timeout) begin
            rx_ready_n <= 1'b0;
        end
    end

    // Transmit-ready pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_ready_n <= 1'b0;
        end else if (!block_mode) begin
            tx_ready_n <= ~thr_empty;
        end else begin
            tx_ready_n <= (tx_count_reg == `UCT_FIFO_DEPTH);
        end
    end

endmodule : uct_channel
`default_nettype wire

/* File: verif/uct_channel_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module uct_channel_sva (
    // Clock, reset and host port
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Receive side and status pins
    input wire logic [7:0] rx_trigger,
    input wire logic [7:0] rx_level,
    input wire logic       tx_serial,
    input wire logic       irq_tx,
    input wire logic       irq_rx,
    input wire logic       rx_ready_n,
    input wire logic       tx_ready_n,
    input wire logic       rx_timeout
);
    logic [7:0] fcr_reg;  // Shadow of fifo control
    logic [7:0] ier_reg;  // Shadow of irq enable
    wire logic  blk = fcr_reg[3] & fcr_reg[0];  // Block mode in force

    // Shadows track host writes, so modes are known without peeking inside
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fcr_reg <= 8'h00;
            ier_reg <= 8'h00;
        end else if (reg_wr && reg_addr == 4'h2) begin
            fcr_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == 4'h1) begin
            ier_reg <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Eight cycles low; two back to back make the shortest bit cell
    sequence s_low8;
        !tx_serial [*8];
    endsequence

    a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    a_reset_pins: assert property ($fell(rst) |-> tx_serial && !irq_tx &&
        !irq_rx && rx_ready_n && !tx_ready_n && !rx_timeout)
        else $error("pins wrong after reset");
    a_rx_ready_n_single: assert property (!$past(blk) |->
        rx_ready_n == ($past(rx_level) == 8'h00))
        else $error("rx ready wrong in single mode");
    a_rx_ready_n_fall: assert property ($past(blk) && $past(rx_level) != 8'h00 &&
        $past(rx_level) >= $past(rx_trigger) |-> !rx_ready_n)
        else $error("rx ready missed trigger");
    a_rx_ready_n_rise: assert property ($past(blk) && $past(rx_level) == 8'h00
        |-> rx_ready_n) else $error("rx ready stuck when empty");
    a_rx_ready_n_hold: assert property ($past(blk) && !$past(rx_ready_n) &&
        $past(rx_level) != 8'h00 |-> !rx_ready_n)
        else $error("rx ready rose before empty");
    a_irq_rx_byte: assert property (!$past(fcr_reg[0]) && $past(ier_reg[0])
        |-> irq_rx == ($past(rx_level) != 8'h00))
        else $error("rx irq wrong without fifo");
    a_irq_rx_trig: assert property ($past(fcr_reg[0]) && $past(ier_reg[0]) &&
        $past(rx_level) >= $past(rx_trigger) |-> irq_rx)
        else $error("rx irq missed trigger");
    a_bit_length: assert property ($fell(tx_serial) |-> s_low8 ##1 s_low8)
        else $error("serial low cell too short");
    a_timeout_data: assert property (rx_timeout |-> $past(rx_level) != 8'h00)
        else $error("timeout with empty fifo");
endmodule : uct_channel_sva

`default_nettype wire

/* File: verif/uct_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none

module uct_rx_model (
    // Clock, reset and command
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       push,
    // Receive FIFO face of the channel
    input wire logic       rx_pop,
    output logic     [7:0] rx_level,
    output logic     [7:0] rx_data,
    output logic           rx_char_in
);
    // Head byte tracks the level, so a stale byte never passes
    assign rx_data = 8'h40 | rx_level;

    // Level counter; a pop of an empty FIFO is ignored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_level   <= 8'h00;
            rx_char_in <= 1'b0;
        end else begin
            rx_level   <= rx_level + {7'h00, push}
                          - {7'h00, rx_pop && rx_level != 8'h00};
            rx_char_in <= push;
        end
    end
endmodule : uct_rx_model

`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic       clk_sys, rst, reg_wr, reg_rd, push, rx_char_in, rx_pop;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_trigger, rx_trigger, rx_level, rx_data;
    logic       tx_serial, irq_tx, irq_rx, rx_ready_n, tx_ready_n, rx_timeout;
    int         n_mismatch, tests_run, i;

    always #20 clk_sys = ~clk_sys;  // 25 MHz

    uct_channel i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_trigger(tx_trigger),
        .rx_trigger(rx_trigger), .rx_level(rx_level), .rx_data(rx_data),
        .rx_char_in(rx_char_in), .rx_pop(rx_pop), .tx_serial(tx_serial),
        .irq_tx(irq_tx), .irq_rx(irq_rx), .rx_ready_n(rx_ready_n),
        .tx_ready_n(tx_ready_n), .rx_timeout(rx_timeout));
    uct_rx_model i_rx (.clk_sys(clk_sys), .rst(rst), .push(push),
        .rx_pop(rx_pop), .rx_level(rx_level), .rx_data(rx_data),
        .rx_char_in(rx_char_in));

    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is looked at in the one cycle it stands
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic pushb;
        @(posedge clk_sys);
        push <= 1'b1;
        @(posedge clk_sys);
        push <= 1'b0;
    endtask : pushb

    // One 8-bit frame sampled mid-cell; bc is clk_sys cycles per bit
    task automatic send(input logic [7:0] d, input int bc, input logic ex);
        int k;
        wr(4'h0, d);
        k = 0;
        while (tx_serial !== 1'b0 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (bc / 2) @(posedge clk_sys);
        #1;
        chk({7'h00, tx_serial}, 8'h00);
        chk({7'h00, irq_tx}, {7'h00, ex});
        for (k = 0; k < 9; k++) begin
            repeat (bc) @(posedge clk_sys);
            #1;
            chk({7'h00, tx_serial}, k < 8 ? {7'h00, d[k]} : 8'h01);
        end
        rd(4'h5, 8'h20);
        repeat (bc) @(posedge clk_sys);
        rd(4'h5, 8'h60);
    endtask : send

    // Cuts a hang short well past the expected run length
    initial begin
        #(40 * 40000);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        {clk_sys, reg_wr, reg_rd, push, reg_addr, reg_wdata} = '0;
        {n_mismatch, tests_run} = '0;
        rst = 1'b1;
        tx_trigger = 8'h03;
        rx_trigger = 8'h04;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({7'h00, tx_ready_n}, 8'h00);
        rd(4'h5, 8'h60);
        rd(4'hf, 8'h00);
        wr(4'h3, 8'h03);
        wr(4'h1, 8'h03);
        wr(4'h6, 8'h01);
        send(8'ha5, 16, 1'b1);
        rd(4'h2, 8'h02);
        rd(4'h2, 8'h01);
        wr(4'h8, 8'h08);
        wr(4'h4, 8'h80);
        wr(4'h6, 8'h02);
        send(8'h3c, 128, 1'b0);
        chk({7'h00, irq_tx}, 8'h01);
        // One byte without FIFO, then block mode round trip
        pushb();
        repeat (3) @(posedge clk_sys);
        #1;
        chk({6'h00, rx_ready_n, irq_rx}, 8'h01);
        rd(4'h0, 8'h41);
        wr(4'h2, 8'h09);
        repeat (3) pushb();
        repeat (2) @(posedge clk_sys);
        #1;
        chk({6'h00, rx_ready_n, irq_rx}, 8'h02);
        pushb();
        repeat (2) @(posedge clk_sys);
        #1;
        chk({6'h00, rx_ready_n, irq_rx}, 8'h01);
        for (i = 4; i > 0; i--) rd(4'h0, 8'h40 | 8'(i));
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h00, rx_ready_n}, 8'h01);
        // Timeout: 44 bits of 16 ticks, tick every 8 cycles
        pushb();
        repeat (5400) @(posedge clk_sys);
        #1;
        chk({7'h00, rx_timeout}, 8'h00);
        i = 0;
        while (rx_timeout !== 1'b1 && i < 600) begin
            @(posedge clk_sys);
            i++;
        end
        #1;
        chk({6'h00, rx_timeout, rx_ready_n}, 8'h02);
        rd(4'h2, 8'h0c);
        rd(4'h0, 8'h41);
        // FIFO mode transmit: first of four bytes goes to the shifter, three queue behind it
        for (i = 1; i < 5; i++) wr(4'h0, 8'(i));
        rd(4'h5, 8'h00);
        chk({6'h00, tx_ready_n, irq_tx}, 8'h00);
        repeat (1400) @(posedge clk_sys);
        #1;
        chk({7'h00, irq_tx}, 8'h01);
        repeat (3000) @(posedge clk_sys);
        rd(4'h5, 8'h20);
        repeat (900) @(posedge clk_sys);
        rd(4'h5, 8'h60);
        // Fill to the brim, then flush so the run stays short
        for (i = 0; i < 129; i++) wr(4'h0, 8'(i));
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h00, tx_ready_n}, 8'h01);
        wr(4'h2, 8'h0d);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h00, tx_ready_n}, 8'h00);
        tally_and_finish();
    end
endmodule : tb

bind uct_channel uct_channel_sva i_sva (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_trigger(rx_trigger),
    .rx_level(rx_level), .tx_serial(tx_serial), .irq_tx(irq_tx),
    .irq_rx(irq_rx), .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n),
    .rx_timeout(rx_timeout));

`default_nettype wire
